/* File: verilog/counter_array_pkg.sv */
// Notes on behaviour
// - reload select steers compare-byte accesses to reload
// - reload values act only in 9-11 bit modulation
// - overflow flag with its enable raises interrupt
// - overflow flag set at selected counter bit
// - overflow flag set by hardware or software write
// - configuration bits 4..2 read zero, ignore writes
// - length field sets 8, 9, 10, 11 bit cycles
// - wide modulation channels ignore length field
// - wide select picks 16-bit or narrow modulation
// - comparator enable turns on compare function
// - rising input edge captures counter value
// - falling input edge captures counter value
// - match with match enable sets event flag
// - match with toggle enable inverts output pin
// - toggle plus modulation gives frequency output
// - modulation enable drives pulse width waveform
// - module interrupt enable masks event flag request
// - low compare byte write clears comparator enable
// - high compare byte write sets comparator enable
// - event flags sticky, cleared only by software
package counter_array_pkg;

    localparam int unsigned NCH = 6;

    localparam logic [7:0] PAGE_CFG  = 8'h0F;
    localparam logic [7:0] PAGE_MOD  = 8'h10;
    localparam logic [7:0] CFG_OFS   = 8'hDA;
    localparam logic [7:0] FLAG_OFS  = 8'hD8;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hE3;

    localparam int unsigned CFG_ARSEL = 7;
    localparam int unsigned CFG_OVIE  = 6;
    localparam int unsigned CFG_OVF   = 5;
    localparam int unsigned CFG_LEN   = 0;

    localparam int unsigned MB_WIDE  = 7;
    localparam int unsigned MB_CMP   = 6;
    localparam int unsigned MB_RISE  = 5;
    localparam int unsigned MB_FALL  = 4;
    localparam int unsigned MB_MATCH = 3;
    localparam int unsigned MB_TOG   = 2;
    localparam int unsigned MB_PWM   = 1;
    localparam int unsigned MB_IRQ   = 0;

    typedef logic [NCH-1:0][7:0] ofs_tbl_t;

    // entry 0 is module 6
    localparam ofs_tbl_t MODE_OFS =
        {8'hDF, 8'hDE, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
    localparam ofs_tbl_t CPL_OFS =
        {8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
    localparam ofs_tbl_t CPH_OFS =
        {8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};

    typedef enum logic [2:0] {
        SEL_NONE, SEL_CFG, SEL_MODE, SEL_CPL, SEL_CPH, SEL_FLAG
    } sel_t;

    // {hit, index} of an address in a table
    function automatic logic [3:0] find_ofs(input logic [7:0] a,
                                            input ofs_tbl_t   t);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NCH; i++) begin
            if (t[i] == a) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] len_mask(input logic [1:0] sel);
        logic [15:0] m;
        case (sel)
            2'd0:    m = 16'h00FF;
            2'd1:    m = 16'h01FF;
            2'd2:    m = 16'h03FF;
            default: m = 16'h07FF;
        endcase
        return m;
    endfunction

endpackage

/* File: verilog/chan_if.sv */
`timescale 1ns/1ps
interface chan_if;
    logic [7:0]  mode;
    logic [15:0] cmp;
    logic [15:0] rld;
    logic [15:0] cnt;
    logic        tick;
    logic        ovf_ev;
    logic [1:0]  clsel;
    logic        match;
    logic        wave;

    modport ctl (output mode, cmp, rld, cnt, tick, ovf_ev, clsel,
                 input  match, wave);
    modport chn (input  mode, cmp, rld, cnt, tick, ovf_ev, clsel,
                 output match, wave);
endinterface // chan_if

/* File: verilog/edge_catch.sv */
`timescale 1ns/1ps
module edge_catch
    import counter_array_pkg::*;
#(
    parameter int unsigned N = NCH
) (
    input  logic         clk_i,   // system clock
    input  logic         rst_n_i, // sync reset, low
    input  logic         ce_i,    // clock enable
    input  logic [N-1:0] pin_i,   // capture inputs
    output logic [N-1:0] rise_o,  // rising edge seen
    output logic [N-1:0] fall_o   // falling edge seen
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic         armed;
    } edge_state_t;

    edge_state_t st_reg;
    edge_state_t st_next;

    // no edge reported before one sample has been taken
    always_comb begin
        st_next       = st_reg;
        st_next.prev  = pin_i;
        st_next.armed = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign rise_o = {N{st_reg.armed & ce_i}} & pin_i & ~st_reg.prev;
    assign fall_o = {N{st_reg.armed & ce_i}} & ~pin_i & st_reg.prev;
endmodule // edge_catch

/* File: verilog/chan_wave.sv */
`timescale 1ns/1ps
module chan_wave
    import counter_array_pkg::*;
(
    input  logic clk_i,   // system clock
    input  logic rst_n_i, // sync reset, low
    input  logic ce_i,    // clock enable
    chan_if.chn  bus      // controls and counter in, match and pin out
);
    typedef struct packed {
        logic [15:0] active;
        logic [7:0]  tgt;
        logic        wave;
    } chan_state_t;

    chan_state_t st_reg;
    chan_state_t st_next;
    logic        wide;
    logic        pwm;
    logic        tog;
    logic        ecom;
    logic        freq;
    logic        hit;
    logic [15:0] msk;

    assign wide = bus.mode[MB_WIDE];
    assign pwm  = bus.mode[MB_PWM];
    assign tog  = bus.mode[MB_TOG];
    assign ecom = bus.mode[MB_CMP];
    assign freq = tog & pwm;
    assign msk  = wide ? 16'hFFFF : len_mask(bus.clsel);

    always_comb begin
        if (!ecom || !bus.tick) begin
            hit = 1'b0;
        end else if (freq) begin
            hit = (bus.cnt[7:0] == st_reg.tgt);
        end else if (pwm) begin
            hit = ((bus.cnt & msk) == (st_reg.active & msk));
        end else begin
            hit = (bus.cnt == bus.cmp);
        end
    end

    always_comb begin
        st_next = st_reg;
        // narrow modulation takes the new compare (8 bit) or reload (9-11 bit) only at a cycle boundary
        if (!pwm || wide) begin
            st_next.active = bus.cmp;
        end else if (bus.ovf_ev) begin
            st_next.active = (bus.clsel == 2'd0) ? bus.cmp : bus.rld;
        end
        if (!freq) begin
            st_next.tgt = bus.cmp[7:0];
        end else if (hit) begin
            st_next.tgt = st_reg.tgt + bus.cmp[15:8];
        end
        if (freq || (tog && !pwm)) begin
            if (hit) begin
                st_next.wave = ~st_reg.wave;
            end
        end else if (pwm) begin
            st_next.wave = ecom &&
                ((bus.cnt & msk) < (st_reg.active & msk));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign bus.match = hit;
    assign bus.wave  = st_reg.wave;

    AST_TOGGLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && tog && !pwm && hit |=> bus.wave != $past(bus.wave))
        else $error("toggle match did not invert the pin");
    AST_PWM_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pwm && !tog && ecom && (bus.cnt & msk) == 16'h0000 &&
        (st_reg.active & msk) != 16'h0000 |=> bus.wave)
        else $error("modulated pin low below compare value");
endmodule // chan_wave

/* File: verilog/counter_array_ctrl.sv */
`timescale 1ns/1ps
module counter_array_ctrl
    import counter_array_pkg::*;
(
    input  logic           SYS_CLK_I, // system clock, 20 MHz
    input  logic           RST_N_I,   // sync reset, active low
    input  logic           CE_I,      // clock enable, low freezes
    input  logic [7:0]     PAGE_I,    // register page
    input  logic [7:0]     ADDR_I,    // register address
    input  logic [7:0]     WDATA_I,   // write data
    input  logic           WR_I,      // write strobe
    input  logic           RD_I,      // read strobe
    output logic [7:0]     RDATA_O,   // read data, cycle after read
    input  logic [15:0]    COUNT_I,   // main counter value
    input  logic           TICK_I,    // counter advances this edge
    input  logic [NCH-1:0] CAP_I,     // capture input pins
    output logic [NCH-1:0] WAVE_O,    // waveform output pins
    output logic           IRQ_O      // counter array interrupt
);
    typedef struct packed {
        logic [7:0]            cfg;
        logic [NCH-1:0][7:0]   mode;
        logic [NCH-1:0][15:0]  cmp;
        logic [NCH-1:0][15:0]  rld;
        logic [NCH-1:0]        flag;
        logic [7:0]            rdata;
        logic                  irq;
    } ctl_state_t;

    localparam ctl_state_t ST_RST = '{
        cfg:     CFG_RST,
        mode:    {NCH{MODE_RST}},
        default: '0
    };

    ctl_state_t     st_reg;
    ctl_state_t     st_next;
    sel_t           sel;
    logic [2:0]     idx;
    logic [3:0]     mode_f;
    logic [3:0]     cpl_f;
    logic [3:0]     cph_f;
    logic [7:0]     rd_val;
    logic [15:0]    cyc_msk;
    logic           ovf_ev;
    logic           arsel;
    logic           wr_cfg;
    logic           wr_cpl;
    logic           wr_cph;
    logic           wr_flag;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] cp_wr;
    logic [NCH-1:0] match_v;
    logic [NCH-1:0] wave_v;
    logic [NCH-1:0] ie_v;
    logic [NCH-1:0] ecom_v;
    logic [NCH-1:0] mat_v;

    assign mode_f = find_ofs(ADDR_I, MODE_OFS);
    assign cpl_f  = find_ofs(ADDR_I, CPL_OFS);
    assign cph_f  = find_ofs(ADDR_I, CPH_OFS);

    // the mode of module 6 shares its address with the configuration
    // register; only the page tells them apart
    always_comb begin
        sel = SEL_NONE;
        idx = 3'd0;
        if (PAGE_I == PAGE_CFG && ADDR_I == CFG_OFS) begin
            sel = SEL_CFG;
        end else if (PAGE_I != PAGE_MOD) begin
            sel = SEL_NONE;
        end else if (mode_f[3]) begin
            sel = SEL_MODE;
            idx = mode_f[2:0];
        end else if (cpl_f[3]) begin
            sel = SEL_CPL;
            idx = cpl_f[2:0];
        end else if (cph_f[3]) begin
            sel = SEL_CPH;
            idx = cph_f[2:0];
        end else if (ADDR_I == FLAG_OFS) begin
            sel = SEL_FLAG;
        end
    end

    assign arsel   = st_reg.cfg[CFG_ARSEL];
    assign wr_cfg  = WR_I && (sel == SEL_CFG);
    assign wr_cpl  = WR_I && (sel == SEL_CPL);
    assign wr_cph  = WR_I && (sel == SEL_CPH);
    assign wr_flag = WR_I && (sel == SEL_FLAG);
    assign cyc_msk = len_mask(st_reg.cfg[CFG_LEN +: 2]);
    assign ovf_ev  = TICK_I && ((COUNT_I & cyc_msk) == cyc_msk);

    always_comb begin
        if (sel == SEL_CFG) begin
            rd_val = st_reg.cfg & CFG_WMASK;
        end else if (sel == SEL_MODE) begin
            rd_val = st_reg.mode[idx];
        end else if (sel == SEL_CPL) begin
            rd_val = arsel ? st_reg.rld[idx][7:0]
                           : st_reg.cmp[idx][7:0];
        end else if (sel == SEL_CPH) begin
            rd_val = arsel ? st_reg.rld[idx][15:8]
                           : st_reg.cmp[idx][15:8];
        end else if (sel == SEL_FLAG) begin
            rd_val = {{(8 - NCH){1'b0}}, st_reg.flag};
        end else begin
            rd_val = 8'h00;
        end
    end

    edge_catch #(
        .N (NCH)
    ) u_edge (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .pin_i   (CAP_I),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    chan_if ch [NCH] ();

    for (genvar g = 0; g < NCH; g++) begin : g_chan
        assign ch[g].mode   = st_reg.mode[g];
        assign ch[g].cmp    = st_reg.cmp[g];
        assign ch[g].rld    = st_reg.rld[g];
        assign ch[g].cnt    = COUNT_I;
        assign ch[g].tick   = TICK_I;
        assign ch[g].ovf_ev = ovf_ev;
        assign ch[g].clsel  = st_reg.cfg[CFG_LEN +: 2];
        assign match_v[g]   = ch[g].match;
        assign wave_v[g]    = ch[g].wave;
        assign ie_v[g]      = st_reg.mode[g][MB_IRQ];
        assign ecom_v[g]    = st_reg.mode[g][MB_CMP];
        assign mat_v[g]     = st_reg.mode[g][MB_MATCH];
        assign cap_ev[g]    = (rise[g] & st_reg.mode[g][MB_RISE])
                            | (fall[g] & st_reg.mode[g][MB_FALL]);
        // a software write to the same compare bytes beats a capture
        assign cp_wr[g]     = (wr_cpl || wr_cph) && !arsel &&
                              (idx == 3'(g));

        chan_wave u_chan (
            .clk_i   (SYS_CLK_I),
            .rst_n_i (RST_N_I),
            .ce_i    (CE_I),
            .bus     (ch[g])
        );
    end

    always_comb begin
        st_next       = st_reg;
        st_next.rdata = 8'h00;
        if (wr_cfg) begin
            st_next.cfg = WDATA_I & CFG_WMASK;
        end else if (WR_I && sel == SEL_MODE) begin
            st_next.mode[idx] = WDATA_I;
        end else if (wr_cpl) begin
            if (arsel) begin
                st_next.rld[idx][7:0] = WDATA_I;
            end else begin
                st_next.cmp[idx][7:0] = WDATA_I;
            end
            st_next.mode[idx][MB_CMP] = 1'b0;
        end else if (wr_cph) begin
            if (arsel) begin
                st_next.rld[idx][15:8] = WDATA_I;
            end else begin
                st_next.cmp[idx][15:8] = WDATA_I;
            end
            st_next.mode[idx][MB_CMP] = 1'b1;
        end else if (wr_flag) begin
            st_next.flag = WDATA_I[NCH-1:0];
        end
        // hardware sets after the write so a set wins over a clear
        if (ovf_ev) begin
            st_next.cfg[CFG_OVF] = 1'b1;
        end
        for (int i = 0; i < NCH; i++) begin
            if (cap_ev[i] && !cp_wr[i]) begin
                st_next.cmp[i] = COUNT_I;
            end
            if (cap_ev[i] || (match_v[i] && mat_v[i])) begin
                st_next.flag[i] = 1'b1;
            end
        end
        if (RD_I) begin
            st_next.rdata = rd_val;
        end
        st_next.irq = (st_reg.cfg[CFG_OVF] && st_reg.cfg[CFG_OVIE])
                    || |(st_reg.flag & ie_v);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            st_reg <= ST_RST;
        end else if (CE_I) begin
            st_reg <= st_next;
        end
    end

    assign RDATA_O = st_reg.rdata;
    assign IRQ_O   = st_reg.irq;
    assign WAVE_O  = wave_v;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // interrupt request
    AST_OVF_IRQ: assert property (
        CE_I && st_reg.cfg[CFG_OVF] && st_reg.cfg[CFG_OVIE] |=> IRQ_O)
        else $error("enabled cycle overflow raised no interrupt");

    AST_FLAG_IRQ: assert property (
        CE_I && |(st_reg.flag & ie_v) |=> IRQ_O)
        else $error("enabled event flag raised no interrupt");

    AST_NO_IRQ: assert property (
        CE_I && !(st_reg.cfg[CFG_OVF] && st_reg.cfg[CFG_OVIE]) &&
        !(|(st_reg.flag & ie_v)) |=> !IRQ_O)
        else $error("interrupt without an enabled source");

    AST_OVF_MASKED: assert property (
        CE_I && !st_reg.cfg[CFG_OVIE] && !(|(st_reg.flag & ie_v)) |=>
        !IRQ_O)
        else $error("masked cycle overflow raised an interrupt");

    // cycle overflow flag and configuration register
    AST_OVF_SET: assert property (
        CE_I && ovf_ev |=> st_reg.cfg[CFG_OVF])
        else $error("cycle overflow not flagged");

    AST_OVF_CAUSE: assert property (
        CE_I && !st_reg.cfg[CFG_OVF] && !ovf_ev &&
        !(wr_cfg && WDATA_I[CFG_OVF]) |=> !st_reg.cfg[CFG_OVF])
        else $error("cycle overflow flagged without a cause");

    AST_OVF_HOLD: assert property (
        CE_I && st_reg.cfg[CFG_OVF] && !wr_cfg |=> st_reg.cfg[CFG_OVF])
        else $error("cycle overflow flag cleared by hardware");

    AST_OVF_SW_SET: assert property (
        CE_I && wr_cfg && WDATA_I[CFG_OVF] |=> st_reg.cfg[CFG_OVF])
        else $error("software write did not set cycle overflow");

    AST_OVF_SW_CLEAR: assert property (
        CE_I && wr_cfg && !WDATA_I[CFG_OVF] && !ovf_ev |=>
        !st_reg.cfg[CFG_OVF])
        else $error("software write did not clear cycle overflow");

    AST_CFG_UNUSED: assert property (
        st_reg.cfg[4:2] == 3'b000)
        else $error("unused configuration bits not zero");

    AST_CFG_READ: assert property (
        CE_I && RD_I && sel == SEL_CFG |=> RDATA_O[4:2] == 3'b000)
        else $error("unused configuration bits read back set");

    // compare bytes: enable side effects and reload steering
    AST_CPL_CLR: assert property (
        CE_I && wr_cpl |=> !ecom_v[$past(idx)])
        else $error("low byte write left comparator enabled");

    AST_CPH_SET: assert property (
        CE_I && wr_cph |=> ecom_v[$past(idx)])
        else $error("high byte write did not enable comparator");

    AST_CPL_CMP_WR: assert property (
        CE_I && wr_cpl && !arsel |=>
        st_reg.cmp[$past(idx)][7:0] == $past(WDATA_I))
        else $error("low byte write missed compare register");

    AST_CPH_CMP_WR: assert property (
        CE_I && wr_cph && !arsel |=>
        st_reg.cmp[$past(idx)][15:8] == $past(WDATA_I))
        else $error("high byte write missed compare register");

    AST_RELOAD_WR: assert property (
        CE_I && wr_cpl && arsel |=>
        st_reg.rld[$past(idx)][7:0] == $past(WDATA_I))
        else $error("reload select write missed reload register");

    AST_RELOAD_WR_HI: assert property (
        CE_I && wr_cph && arsel |=>
        st_reg.rld[$past(idx)][15:8] == $past(WDATA_I))
        else $error("reload select write missed reload high byte");

    AST_RELOAD_KEEP: assert property (
        CE_I && (wr_cpl || wr_cph) && !arsel |=>
        st_reg.rld[$past(idx)] == $past(st_reg.rld[idx]))
        else $error("compare write disturbed a reload register");

    AST_RELOAD_READ: assert property (
        CE_I && RD_I && sel == SEL_CPL && arsel |=>
        RDATA_O == $past(st_reg.rld[idx][7:0]))
        else $error("reload select read missed reload register");

    AST_COMPARE_READ: assert property (
        CE_I && RD_I && sel == SEL_CPH && !arsel |=>
        RDATA_O == $past(st_reg.cmp[idx][15:8]))
        else $error("compare read returned the wrong byte");

    // event flags
    AST_FLAG_STICKY: assert property (
        CE_I && !wr_flag |=>
        (st_reg.flag & $past(st_reg.flag)) == $past(st_reg.flag))
        else $error("event flag cleared by hardware");

    // per module: capture, match and software clear
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        AST_CAPTURE: assert property (
            CE_I && cap_ev[g] && !cp_wr[g] |=>
            st_reg.cmp[g] == $past(COUNT_I) && st_reg.flag[g])
            else $error("capture edge did not store counter");

        AST_MATCH_FLAG: assert property (
            CE_I && match_v[g] && mat_v[g] |=> st_reg.flag[g])
            else $error("match did not set event flag");

        AST_CMP_HOLD: assert property (
            CE_I && !cap_ev[g] && !cp_wr[g] |=>
            st_reg.cmp[g] == $past(st_reg.cmp[g]))
            else $error("compare value changed without capture or write");

        AST_FLAG_CAUSE: assert property (
            CE_I && !wr_flag && !st_reg.flag[g] && !cap_ev[g] &&
            !(match_v[g] && mat_v[g]) |=> !st_reg.flag[g])
            else $error("event flag set without a match or capture");

        AST_FLAG_SW_CLEAR: assert property (
            CE_I && wr_flag && !WDATA_I[g] && !cap_ev[g] &&
            !(match_v[g] && mat_v[g]) |=> !st_reg.flag[g])
            else $error("software write did not clear event flag");
    end

    COV_OVF_IRQ: cover property (
        CE_I && ovf_ev && st_reg.cfg[CFG_OVIE] ##1 IRQ_O ##1 IRQ_O);
    COV_CAPTURE: cover property (CE_I && |cap_ev);
    COV_RELOAD: cover property (CE_I && wr_cph && arsel);
    COV_WAVE: cover property (|wave_v ##1 !(|wave_v));
    COV_FLAG_CLEAR: cover property (CE_I && wr_flag && |st_reg.flag);
endmodule // counter_array_ctrl

/* File: tb/pin_side_model.sv */
`timescale 1ns/1ps
module pin_side_model
    import counter_array_pkg::*;
(
    input  logic           clk_i,  // system clock
    input  logic [NCH-1:0] wave_i, // waveform pins from the block
    output logic [NCH-1:0] cap_o   // capture pins to the block
);
    logic [NCH-1:0] wave_seen;

    initial begin
        cap_o = '0;
    end

    // a slow source moves its pin only some cycles after being asked
    task automatic set_pin(input int idx, input logic lvl, input int lag);
        repeat (lag) @(posedge clk_i);
        cap_o[idx] <= lvl;
        @(posedge clk_i);
    endtask

    // the pin is seen one flop later, as an outside receiver would
    always_ff @(posedge clk_i) begin
        wave_seen <= wave_i;
    end
endmodule // pin_side_model

/* File: tb/counter_array_mode_control_tb_top.sv */
`timescale 1ns/1ps
module counter_array_mode_control_tb_top
    import counter_array_pkg::*;
;
    logic           clk;
    logic           rst_n;
    logic           ce;
    logic [7:0]     page;
    logic [7:0]     addr;
    logic [7:0]     wdata;
    logic           wr;
    logic           rd;
    logic [7:0]     rdata;
    logic [15:0]    count;
    logic           tick;
    logic [NCH-1:0] cap;
    logic [NCH-1:0] wave;
    logic           irq;
    int             fails;
    int             n_checks;

    counter_array_ctrl i_dut (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PAGE_I(page),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .COUNT_I(count), .TICK_I(tick), .CAP_I(cap),
        .WAVE_O(wave), .IRQ_O(irq)
    );

    pin_side_model i_pins (.clk_i(clk), .wave_i(wave), .cap_o(cap));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] pg, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        page  <= pg;
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic expect_reg(input logic [7:0] pg, input logic [7:0] a,
                              input logic [7:0] exp);
        @(posedge clk);
        page <= pg;
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask

    // low byte first: the high byte write leaves the comparator on
    task automatic wr_cmp(input int i, input logic [15:0] v);
        wr_reg(PAGE_MOD, CPL_OFS[i], v[7:0]);
        wr_reg(PAGE_MOD, CPH_OFS[i], v[15:8]);
    endtask

    task automatic pulse(input logic [15:0] c);
        @(posedge clk);
        count <= c;
        tick  <= 1'b1;
        @(posedge clk);
        tick  <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic pin_is(input int k, input logic exp);
        check({15'h0000, i_pins.wave_seen[k]}, {15'h0000, exp});
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    initial begin
        logic w;
        fails = 0;
        n_checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        page = 8'h00;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        count = 16'h0000;
        tick = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;

        expect_reg(PAGE_CFG, CFG_OFS, 8'h00);
        for (int i = 0; i < NCH; i++) begin
            expect_reg(PAGE_MOD, MODE_OFS[i], 8'h00);
        end
        expect_reg(PAGE_MOD, 8'h80, 8'h00);
        check({15'h0000, irq}, 16'h0000);
        $display("test reset done");

        wr_reg(PAGE_CFG, CFG_OFS, 8'hFF);
        expect_reg(PAGE_CFG, CFG_OFS, 8'hE3);
        repeat (2) @(posedge clk);
        check({15'h0000, irq}, 16'h0001);
        wr_reg(PAGE_CFG, CFG_OFS, 8'hC3);
        expect_reg(PAGE_CFG, CFG_OFS, 8'hC3);
        check({15'h0000, irq}, 16'h0000);
        wr_reg(PAGE_CFG, CFG_OFS, 8'h20);
        expect_reg(PAGE_CFG, CFG_OFS, 8'h20);
        check({15'h0000, irq}, 16'h0000);
        wr_reg(PAGE_CFG, CFG_OFS, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(PAGE_CFG, CFG_OFS, 8'h40);
        ce <= 1'b1;
        expect_reg(PAGE_CFG, CFG_OFS, 8'h00);
        $display("test config done");

        // the smaller all-ones value is one bit short of the selected length and must not set the flag
        for (int len = 0; len < 4; len++) begin
            wr_reg(PAGE_CFG, CFG_OFS, 8'(len));
            pulse((16'h0080 << len) - 16'h0001);
            expect_reg(PAGE_CFG, CFG_OFS, 8'(len));
            pulse((16'h0100 << len) - 16'h0001);
            expect_reg(PAGE_CFG, CFG_OFS, 8'(len) | 8'h20);
        end
        wr_reg(PAGE_CFG, CFG_OFS, 8'h00);
        $display("test overflow done");

        for (int i = 0; i < NCH; i++) begin
            wr_reg(PAGE_MOD, MODE_OFS[i], 8'h5A);
            expect_reg(PAGE_MOD, MODE_OFS[i], 8'h5A);
            wr_reg(PAGE_MOD, CPL_OFS[i], 8'h00);
            expect_reg(PAGE_MOD, MODE_OFS[i], 8'h1A);
            wr_reg(PAGE_MOD, CPH_OFS[i], 8'h00);
            expect_reg(PAGE_MOD, MODE_OFS[i], 8'h5A);
            wr_reg(PAGE_MOD, MODE_OFS[i], 8'h00);
        end
        $display("test modes done");

        wr_reg(PAGE_MOD, MODE_OFS[0], 8'h21);
        wr_reg(PAGE_MOD, MODE_OFS[1], 8'h10);
        count <= 16'h1234;
        i_pins.set_pin(0, 1'b1, 0);
        repeat (3) @(posedge clk);
        expect_reg(PAGE_MOD, CPL_OFS[0], 8'h34);
        expect_reg(PAGE_MOD, CPH_OFS[0], 8'h12);
        expect_reg(PAGE_MOD, FLAG_OFS, 8'h01);
        check({15'h0000, irq}, 16'h0001);
        @(posedge clk);
        count <= 16'h5678;
        i_pins.set_pin(0, 1'b0, 2);
        repeat (3) @(posedge clk);
        expect_reg(PAGE_MOD, CPL_OFS[0], 8'h34);
        wr_reg(PAGE_MOD, FLAG_OFS, 8'h00);
        repeat (2) @(posedge clk);
        check({15'h0000, irq}, 16'h0000);
        count <= 16'h0ABC;
        i_pins.set_pin(1, 1'b1, 0);
        i_pins.set_pin(1, 1'b0, 1);
        repeat (3) @(posedge clk);
        expect_reg(PAGE_MOD, CPL_OFS[1], 8'hBC);
        expect_reg(PAGE_MOD, CPH_OFS[1], 8'h0A);
        expect_reg(PAGE_MOD, FLAG_OFS, 8'h02);
        check({15'h0000, irq}, 16'h0000);
        wr_reg(PAGE_MOD, FLAG_OFS, 8'h00);
        wr_reg(PAGE_MOD, MODE_OFS[0], 8'h00);
        wr_reg(PAGE_MOD, MODE_OFS[1], 8'h00);
        $display("test capture done");

        wr_cmp(2, 16'h0300);
        wr_reg(PAGE_MOD, MODE_OFS[2], 8'h4D);
        w = i_pins.wave_seen[2];
        pulse(16'h0300);
        expect_reg(PAGE_MOD, FLAG_OFS, 8'h04);
        pin_is(2, ~w);
        check({15'h0000, irq}, 16'h0001);
        pulse(16'h0301);
        pin_is(2, ~w);
        wr_reg(PAGE_MOD, FLAG_OFS, 8'h00);
        wr_reg(PAGE_MOD, MODE_OFS[2], 8'h00);
        $display("test match done");

        wr_cmp(3, 16'h2010);
        wr_reg(PAGE_MOD, MODE_OFS[3], 8'h46);
        w = i_pins.wave_seen[3];
        pulse(16'h0010);
        pin_is(3, ~w);
        pulse(16'h0010);
        pin_is(3, ~w);
        pulse(16'h0030);
        pin_is(3, w);
        wr_reg(PAGE_MOD, MODE_OFS[3], 8'h00);
        $display("test frequency done");

        wr_cmp(4, 16'h0090);
        wr_reg(PAGE_CFG, CFG_OFS, 8'h80);
        wr_cmp(4, 16'h0040);
        expect_reg(PAGE_MOD, CPL_OFS[4], 8'h40);
        wr_reg(PAGE_CFG, CFG_OFS, 8'h00);
        expect_reg(PAGE_MOD, CPL_OFS[4], 8'h90);
        wr_reg(PAGE_MOD, MODE_OFS[4], 8'h42);
        pulse(16'h00FF);
        pulse(16'h0080);
        pin_is(4, 1'b1);
        wr_reg(PAGE_CFG, CFG_OFS, 8'h01);
        pulse(16'h01FF);
        pulse(16'h0080);
        pin_is(4, 1'b0);
        wr_reg(PAGE_CFG, CFG_OFS, 8'h00);
        wr_reg(PAGE_MOD, MODE_OFS[4], 8'h00);
        $display("test narrow pwm done");

        wr_cmp(5, 16'h1000);
        wr_reg(PAGE_MOD, MODE_OFS[5], 8'hC2);
        pulse(16'h0800);
        pin_is(5, 1'b1);
        pulse(16'h2000);
        pin_is(5, 1'b0);
        pulse(16'h0000);
        pin_is(5, 1'b1);
        $display("test wide pwm done");
        print_verdict();
    end
endmodule // counter_array_mode_control_tb_top
